// [sticky_flag.sv]
// one write-one-to-clear status flag, set wins over clear
`timescale 1ns/100ps
module sticky_flag (
    input  wire logic mclk,
    input  wire logic rstn,
    sticky_if.keeper  bus
);

    // flag storage, event beats a clear in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bus.q <= 1'b0;
        end else if (bus.set) begin
            bus.q <= 1'b1;
        end else if (bus.clr) begin
            bus.q <= 1'b0;
        end
    end

    property p_set_wins;
        @(posedge mclk) disable iff (!rstn)
        bus.set |=> bus.q;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("flag lost an event");

endmodule : sticky_flag

// [sticky_if.sv]
// carrier for one sticky status flag: set, clear and value
`timescale 1ns/100ps
interface sticky_if;
    logic set;
    logic clr;
    logic q;
    modport keeper (input set, input clr, output q);
    modport user   (output set, output clr, input q);
endinterface : sticky_if

// [tb_wdt_mailbox.sv]
// self-checking bench for the watchdog and mailbox block
`timescale 1ns/100ps
module tb_wdt_mailbox
    import wdt_pkg::*;
();

    // ********************************************************************
    // signals and instance
    // ********************************************************************
    localparam int unsigned TCYC = 8;

    logic       mclk;
    logic       rstn;
    logic       io_wr;
    logic       io_rd;
    logic [4:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       hub_serr_msg;
    logic       hub_nmi_msg;
    logic       bridge_system_error_enable;
    logic       nmi_to_smi_route;
    logic [1:0] interrupt_line_select;
    logic       smi_pulse;
    logic       nmi_pulse;
    logic       irq_pulse;
    logic [1:0] irq_line;
    logic       signaled_system_error;
    logic       timeout_pulse;
    int         mismatches = 0;
    int         checks     = 0;
    int         smi_cnt    = 0;
    int         nmi_cnt    = 0;
    int         irq_cnt    = 0;
    int         to_cnt     = 0;
    int         n;
    int         s0;
    int         n0;
    int         t0;
    int         i0;

    wdt_mailbox #(.TICK_CYCLES(TCYC)) DUT (
        .mclk                       (mclk),
        .rstn                       (rstn),
        .io_wr                      (io_wr),
        .io_rd                      (io_rd),
        .io_addr                    (io_addr),
        .io_wdata                   (io_wdata),
        .io_rdata                   (io_rdata),
        .hub_serr_msg               (hub_serr_msg),
        .hub_nmi_msg                (hub_nmi_msg),
        .bridge_system_error_enable (bridge_system_error_enable),
        .nmi_to_smi_route           (nmi_to_smi_route),
        .interrupt_line_select      (interrupt_line_select),
        .smi_pulse                  (smi_pulse),
        .nmi_pulse                  (nmi_pulse),
        .irq_pulse                  (irq_pulse),
        .irq_line                   (irq_line),
        .signaled_system_error      (signaled_system_error),
        .timeout_pulse              (timeout_pulse)
    );

    // clock at 100 MHz
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // count one-cycle pulses seen on the outputs
    always @(posedge mclk) begin
        if (smi_pulse === 1'b1) smi_cnt++;
        if (nmi_pulse === 1'b1) nmi_cnt++;
        if (irq_pulse === 1'b1) irq_cnt++;
        if (timeout_pulse === 1'b1) to_cnt++;
    end

    // ********************************************************************
    // tasks
    // ********************************************************************
    task end_of_test;
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task check(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : check

    // one byte write, strobe held for exactly one taking edge
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        io_wr    <= 1'b1;
        io_addr  <= a;
        io_wdata <= d;
        @(posedge mclk);
        io_wr    <= 1'b0;
    endtask : wr

    // one byte read, data registered at the taking edge
    task rd(input logic [4:0] a, input logic [7:0] e, input string what);
        @(posedge mclk);
        io_rd   <= 1'b1;
        io_addr <= a;
        @(posedge mclk);
        io_rd   <= 1'b0;
        #1;
        check(what, e, io_rdata);
    endtask : rd

    // one-cycle hub message, then let flags and escalation settle
    task hub_msg(input bit nmi);
        @(posedge mclk);
        if (nmi) hub_nmi_msg <= 1'b1;
        else hub_serr_msg <= 1'b1;
        @(posedge mclk);
        hub_nmi_msg  <= 1'b0;
        hub_serr_msg <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : hub_msg

    // ********************************************************************
    // main sequence
    // ********************************************************************
    initial begin
        rstn = 1'b0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 5'h00;
        io_wdata = 8'h00;
        hub_serr_msg = 1'b0;
        hub_nmi_msg = 1'b0;
        bridge_system_error_enable = 1'b0;
        nmi_to_smi_route = 1'b0;
        interrupt_line_select = 2'h0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        // values after reset, unmapped offset
        rd(OFF_RELOAD, 8'h00, "count reset");
        rd(OFF_INIT, 8'h04, "init reset");
        rd(OFF_OS_TO_HNDLR, 8'h00, "os box reset");
        rd(OFF_HNDLR_TO_OS, 8'h00, "handler box reset");
        rd(OFF_STATUS_LO, 8'h00, "status lo reset");
        rd(OFF_STATUS_HI, 8'h00, "status hi reset");
        rd(5'h10, 8'h00, "unmapped read");
        // initial value zero and one refused, reserved bits dropped
        wr(OFF_INIT, 8'h00);
        rd(OFF_INIT, 8'h04, "init after 00");
        wr(OFF_INIT, 8'h01);
        rd(OFF_INIT, 8'h04, "init after 01");
        wr(OFF_INIT, 8'hFF);
        rd(OFF_INIT, 8'h3F, "init after ff");
        check("timeout while stopped", 8'h00, 8'(to_cnt));
        wr(OFF_RELOAD, 8'h00);
        rd(OFF_RELOAD, 8'h3F, "count six bits");
        wr(OFF_INIT, 8'hC3);
        rd(OFF_INIT, 8'h03, "init after c3");
        t0 = to_cnt;
        wr(OFF_RELOAD, 8'h5A);
        rd(OFF_RELOAD, 8'h03, "count reloaded");
        n = 2;
        while (to_cnt == t0) begin
            if (n >= 200) begin
                mismatches++;
                end_of_test();
            end
            @(posedge mclk);
            n++;
        end
        check("timeout period", 8'h01,
              {7'h00, (n >= 3 * TCYC && n <= 3 * TCYC + 6)});
        rd(OFF_RELOAD, 8'h00, "count at end");
        repeat (3 * TCYC) @(posedge mclk);
        check("timeout count", 8'h01, 8'(to_cnt - t0));
        t0 = to_cnt;
        wr(OFF_RELOAD, 8'h11);
        repeat (20) @(posedge mclk);
        wr(OFF_RELOAD, 8'h22);
        repeat (20) @(posedge mclk);
        rd(OFF_RELOAD, 8'h01, "count two ticks");
        check("timeout averted", 8'h00, 8'(to_cnt - t0));
        s0 = smi_cnt;
        wr(OFF_OS_TO_HNDLR, 8'h96);
        repeat (2) @(posedge mclk);
        check("smi on os write", 8'h01, 8'(smi_cnt - s0));
        rd(OFF_OS_TO_HNDLR, 8'h96, "os box data");
        rd(OFF_STATUS_LO, 8'h08, "smi flag");
        wr(OFF_STATUS_LO, 8'h00);
        rd(OFF_STATUS_LO, 8'h08, "smi flag kept");
        wr(OFF_STATUS_LO, 8'h08);
        rd(OFF_STATUS_LO, 8'h00, "smi flag cleared");
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk);
            interrupt_line_select <= 2'(s);
            i0 = irq_cnt;
            wr(OFF_HNDLR_TO_OS, 8'hC0 | 8'(s));
            repeat (2) @(posedge mclk);
            check("irq on handler write", 8'h01, 8'(irq_cnt - i0));
            check("irq line", 8'(s), {6'h00, irq_line});
            rd(OFF_HNDLR_TO_OS, 8'hC0 | 8'(s), "handler box");
            rd(OFF_STATUS_LO, 8'h04, "int flag");
            wr(OFF_STATUS_LO, 8'h04);
        end
        @(posedge mclk);
        interrupt_line_select <= 2'h0;
        repeat (2) @(posedge mclk);
        check("irq line held", 8'h03, {6'h00, irq_line});
        rd(OFF_STATUS_LO, 8'h00, "int flag cleared");
        n0 = nmi_cnt;
        s0 = smi_cnt;
        hub_msg(1'b0);
        rd(OFF_STATUS_HI, 8'h10, "serr flag");
        check("sse off", 8'h00, {7'h00, signaled_system_error});
        check("nmi disabled", 8'h00, 8'(nmi_cnt - n0));
        wr(OFF_STATUS_HI, 8'h00);
        rd(OFF_STATUS_HI, 8'h10, "serr flag kept");
        @(posedge mclk);
        bridge_system_error_enable <= 1'b1;
        repeat (4) @(posedge mclk);
        check("sse on", 8'h01, {7'h00, signaled_system_error});
        check("nmi enabled", 8'h01, 8'(nmi_cnt - n0));
        check("no smi", 8'h00, 8'(smi_cnt - s0));
        wr(OFF_STATUS_HI, 8'h10);
        rd(OFF_STATUS_HI, 8'h00, "serr cleared");
        check("sse gone", 8'h00, {7'h00, signaled_system_error});
        @(posedge mclk);
        nmi_to_smi_route <= 1'b1;
        hub_msg(1'b0);
        repeat (2) @(posedge mclk);
        check("routed smi", 8'h01, 8'(smi_cnt - s0));
        check("routed no nmi", 8'h01, 8'(nmi_cnt - n0));
        wr(OFF_STATUS_HI, 8'h10);
        @(posedge mclk);
        bridge_system_error_enable <= 1'b0;
        nmi_to_smi_route <= 1'b0;
        hub_msg(1'b1);
        rd(OFF_STATUS_HI, 8'h08, "nmi flag");
        wr(OFF_STATUS_HI, 8'hFF);
        rd(OFF_STATUS_HI, 8'h00, "status hi cleared");
        rd(OFF_STATUS_LO, 8'h00, "status lo quiet");
        end_of_test();
    end

endmodule : tb_wdt_mailbox

// [tick_gen.sv]
// prescaler giving one-cycle tick pulses every CYCLES clocks
`timescale 1ns/100ps
module tick_gen
    import wdt_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES_DEFAULT
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic restart,
    output logic      tick
);

    localparam logic [TICK_W-1:0] LAST = TICK_W'(CYCLES - 1);

    logic [TICK_W-1:0] cnt_reg;
    logic [TICK_W-1:0] cnt_next;
    logic              wrap;

    // wrap detection and next count
    assign wrap     = (cnt_reg == LAST);
    assign cnt_next = (restart || wrap) ? '0 : cnt_reg + 1'b1;

    // counter and tick flop
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick    <= wrap && !restart;
        end
    end

    property p_tick_period;
        @(posedge mclk) disable iff (!rstn)
        tick |-> ($past(cnt_reg) == LAST) && (cnt_reg == '0);
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("tick not on prescaler wrap");

endmodule : tick_gen

// [wdt_mailbox.sv]
// watchdog countdown, two mailboxes and hub message status
//
// Overview of operation
// - reading reload register returns current count
// - any reload write restarts from initial value
// - count bits seven and six read zero
// - six-bit initial value, reset value four
// - initial values zero and one are ignored
// - countdown steps about every 0.6 seconds
// - os mailbox write stores, smi, sets flag
// - handler mailbox write stores, flag, selected irq
// - hub error message sets status bit twelve
// - hub error flag cleared only writing one
// - error flag with enable: sse, nmi or smi
// - hub nmi message sets bit eleven, w1c
`timescale 1ns/100ps
module wdt_mailbox
    import wdt_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [4:0] io_addr,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    input  wire logic       hub_serr_msg,
    input  wire logic       hub_nmi_msg,
    input  wire logic       bridge_system_error_enable,
    input  wire logic       nmi_to_smi_route,
    input  wire logic [1:0] interrupt_line_select,
    output logic            smi_pulse,
    output logic            nmi_pulse,
    output logic            irq_pulse,
    output logic      [1:0] irq_line,
    output logic            signaled_system_error,
    output logic            timeout_pulse
);

    // ********************************************************************
    // storage
    // ********************************************************************
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] init_reg;
    logic [CNT_W-1:0] init_next;
    logic [7:0]       os_box_reg;
    logic [7:0]       hnd_box_reg;
    logic             serr_cond_reg;
    logic             tick;

    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_clr;
    logic [NUM_FLAGS-1:0] flag_q;

    // ********************************************************************
    // address decode
    // ********************************************************************
    logic wr_reload;
    logic wr_init;
    logic wr_os_box;
    logic wr_hnd_box;
    logic wr_sts_lo;
    logic wr_sts_hi;
    logic init_ok;

    // write strobes per register
    assign wr_reload  = io_wr && (io_addr == OFF_RELOAD);
    assign wr_init    = io_wr && (io_addr == OFF_INIT);
    assign wr_os_box  = io_wr && (io_addr == OFF_OS_TO_HNDLR);
    assign wr_hnd_box = io_wr && (io_addr == OFF_HNDLR_TO_OS);
    assign wr_sts_lo  = io_wr && (io_addr == OFF_STATUS_LO);
    assign wr_sts_hi  = io_wr && (io_addr == OFF_STATUS_HI);

    assign init_ok    = (io_wdata[CNT_W-1:0] >= INIT_MIN);

    // ********************************************************************
    // countdown
    // ********************************************************************
    logic count_live;
    logic timeout_next;

    assign count_live = (count_reg != COUNT_ZERO);

    assign count_next = wr_reload              ? init_reg :
                        (tick && count_live)   ? count_reg - COUNT_ONE :
                                                 count_reg;

    assign timeout_next = !wr_reload && tick && (count_reg == COUNT_ONE);

    assign init_next = (wr_init && init_ok) ? io_wdata[CNT_W-1:0] : init_reg;

    // 0.6 s step source, realigned on reload
    tick_gen #(
        .CYCLES  (TICK_CYCLES)
    ) u_tick (
        .mclk    (mclk),
        .rstn    (rstn),
        .restart (wr_reload),
        .tick    (tick)
    );

    // timer registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= COUNT_RESET;
            init_reg  <= INIT_RESET;
        end else begin
            count_reg <= count_next;
            init_reg  <= init_next;
        end
    end

    // ********************************************************************
    // mailboxes
    // ********************************************************************
    // store mailbox bytes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            os_box_reg  <= MAILBOX_RESET;
            hnd_box_reg <= MAILBOX_RESET;
        end else begin
            if (wr_os_box) begin
                os_box_reg <= io_wdata;
            end
            if (wr_hnd_box) begin
                hnd_box_reg <= io_wdata;
            end
        end
    end

    // ********************************************************************
    // status flags
    // ********************************************************************
    // flag set events
    assign flag_set[FLAG_INT]    = wr_hnd_box;
    assign flag_set[FLAG_SW_SMI] = wr_os_box;
    assign flag_set[FLAG_NMI]    = hub_nmi_msg;
    assign flag_set[FLAG_SERR]   = hub_serr_msg;

    assign flag_clr[FLAG_INT]    = wr_sts_lo && io_wdata[STS_INT_BIT];
    assign flag_clr[FLAG_SW_SMI] = wr_sts_lo && io_wdata[STS_SMI_BIT];
    assign flag_clr[FLAG_NMI]    = wr_sts_hi && io_wdata[STS_NMI_BIT - 8];
    assign flag_clr[FLAG_SERR]   = wr_sts_hi && io_wdata[STS_SERR_BIT - 8];

    sticky_if flag_bus [NUM_FLAGS] ();

    // one sticky flag per status bit
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        assign flag_bus[i].set = flag_set[i];
        assign flag_bus[i].clr = flag_clr[i];
        assign flag_q[i]       = flag_bus[i].q;
        sticky_flag u_flag (
            .mclk (mclk),
            .rstn (rstn),
            .bus  (flag_bus[i])
        );
    end

    // ********************************************************************
    // event outputs
    // ********************************************************************
    logic serr_cond;
    logic serr_rise;

    // error flag gated by bridge enable
    assign serr_cond = flag_q[FLAG_SERR] && bridge_system_error_enable;
    assign serr_rise = serr_cond && !serr_cond_reg;

    // registered event pulses and levels
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            serr_cond_reg         <= 1'b0;
            smi_pulse             <= 1'b0;
            nmi_pulse             <= 1'b0;
            irq_pulse             <= 1'b0;
            irq_line              <= 2'b00;
            signaled_system_error <= 1'b0;
            timeout_pulse         <= 1'b0;
        end else begin
            serr_cond_reg         <= serr_cond;
            smi_pulse             <= wr_os_box
                                     || (serr_rise && nmi_to_smi_route);
            nmi_pulse             <= serr_rise && !nmi_to_smi_route;
            irq_pulse             <= wr_hnd_box;
            signaled_system_error <= serr_cond;
            timeout_pulse         <= timeout_next;
            if (wr_hnd_box) begin
                irq_line <= interrupt_line_select;
            end
        end
    end

    // ********************************************************************
    // read path
    // ********************************************************************
    logic [15:0] status_word;
    logic [7:0]  read_mux;

    // reserved status bits read zero
    // bits 10:4 are seven reserved zeros, keeping the word at 16 bits
    assign status_word = {3'b000, flag_q[FLAG_SERR], flag_q[FLAG_NMI],
                          7'h00, flag_q[FLAG_SW_SMI], flag_q[FLAG_INT],
                          2'b00};

    assign read_mux = (io_addr == OFF_RELOAD)      ? {2'b00, count_reg}   :
                      (io_addr == OFF_INIT)        ? {2'b00, init_reg}    :
                      (io_addr == OFF_OS_TO_HNDLR) ? os_box_reg           :
                      (io_addr == OFF_HNDLR_TO_OS) ? hnd_box_reg          :
                      (io_addr == OFF_STATUS_LO)   ? status_word[7:0]     :
                      (io_addr == OFF_STATUS_HI)   ? status_word[15:8]    :
                                                     8'h00;

    // read data register, held between reads
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            io_rdata <= RDATA_RESET;
        end else if (io_rd) begin
            io_rdata <= read_mux;
        end
    end

    // ********************************************************************
    // checks
    // ********************************************************************
    property p_read_count;
        @(posedge mclk) disable iff (!rstn)
        io_rd && (io_addr == OFF_RELOAD) |=>
            io_rdata == {2'b00, $past(count_reg)};
    endproperty
    a_read_count: assert property (p_read_count)
        else $error("count read mismatch");

    property p_reload;
        @(posedge mclk) disable iff (!rstn)
        wr_reload |=> count_reg == $past(init_reg);
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload did not restore initial value");

    property p_top_zero;
        @(posedge mclk) disable iff (!rstn)
        io_rd && (io_addr == OFF_RELOAD) |=> io_rdata[7:6] == 2'b00;
    endproperty
    a_top_zero: assert property (p_top_zero)
        else $error("count top bits not zero");

    property p_init_load;
        @(posedge mclk) disable iff (!rstn)
        wr_init && init_ok |=> init_reg == $past(io_wdata[CNT_W-1:0]);
    endproperty
    a_init_load: assert property (p_init_load)
        else $error("initial value not stored");

    property p_init_ignore;
        @(posedge mclk) disable iff (!rstn)
        wr_init && !init_ok |=> $stable(init_reg);
    endproperty
    a_init_ignore: assert property (p_init_ignore)
        else $error("forbidden initial value accepted");

    property p_os_box;
        @(posedge mclk) disable iff (!rstn)
        wr_os_box |=> smi_pulse && flag_q[FLAG_SW_SMI]
                      && (os_box_reg == $past(io_wdata));
    endproperty
    a_os_box: assert property (p_os_box)
        else $error("os mailbox write effects missing");

    property p_hnd_box;
        @(posedge mclk) disable iff (!rstn)
        wr_hnd_box |=> irq_pulse && flag_q[FLAG_INT]
                       && (irq_line == $past(interrupt_line_select));
    endproperty
    a_hnd_box: assert property (p_hnd_box)
        else $error("handler mailbox write effects missing");

    property p_serr_set;
        @(posedge mclk) disable iff (!rstn)
        hub_serr_msg |=> flag_q[FLAG_SERR];
    endproperty
    a_serr_set: assert property (p_serr_set)
        else $error("hub error flag not set");

    property p_serr_hold;
        @(posedge mclk) disable iff (!rstn)
        flag_q[FLAG_SERR] && !flag_clr[FLAG_SERR] |=> flag_q[FLAG_SERR];
    endproperty
    a_serr_hold: assert property (p_serr_hold)
        else $error("hub error flag dropped without clear");

    property p_sse;
        @(posedge mclk) disable iff (!rstn)
        serr_rise |=> signaled_system_error && (nmi_pulse != smi_pulse
                      || $past(wr_os_box));
    endproperty
    a_sse: assert property (p_sse)
        else $error("error escalation missing");

    property p_nmi_set;
        @(posedge mclk) disable iff (!rstn)
        hub_nmi_msg |=> flag_q[FLAG_NMI];
    endproperty
    a_nmi_set: assert property (p_nmi_set)
        else $error("hub nmi flag not set");

    property p_step;
        @(posedge mclk) disable iff (!rstn)
        tick && count_live && !wr_reload |=>
            (count_reg == $past(count_reg) - COUNT_ONE)
            && (timeout_pulse == ($past(count_reg) == COUNT_ONE));
    endproperty
    a_step: assert property (p_step)
        else $error("countdown step or timeout wrong");

    property p_rsvd;
        @(posedge mclk) disable iff (!rstn)
        io_rd && (io_addr == OFF_STATUS_HI) |=> io_rdata[7:5] == 3'b000;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved status bits not zero");

endmodule : wdt_mailbox

// [wdt_pkg.sv]
// constants shared by the watchdog and mailbox block
package wdt_pkg;

    // ********************************************************************
    // register offsets within the 32-byte io window
    // ********************************************************************
    localparam logic [4:0] OFF_RELOAD      = 5'h00;
    localparam logic [4:0] OFF_INIT        = 5'h01;
    localparam logic [4:0] OFF_OS_TO_HNDLR = 5'h02;
    localparam logic [4:0] OFF_HNDLR_TO_OS = 5'h03;
    localparam logic [4:0] OFF_STATUS_LO   = 5'h04;
    localparam logic [4:0] OFF_STATUS_HI   = 5'h05;

    // ********************************************************************
    // widths and values after reset
    // ********************************************************************
    localparam int         CNT_W         = 6;
    localparam int         TICK_W        = 32;
    localparam logic [5:0] COUNT_RESET   = 6'h00;
    localparam logic [5:0] INIT_RESET    = 6'h04;
    localparam logic [7:0] MAILBOX_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET   = 8'h00;
    localparam logic [5:0] INIT_MIN      = 6'h02;
    localparam logic [5:0] COUNT_ONE     = 6'h01;
    localparam logic [5:0] COUNT_ZERO    = 6'h00;

    // ********************************************************************
    // status flag positions (whole 16-bit register)
    // ********************************************************************
    localparam int NUM_FLAGS    = 4;
    localparam int FLAG_INT     = 0;
    localparam int FLAG_SW_SMI  = 1;
    localparam int FLAG_NMI     = 2;
    localparam int FLAG_SERR    = 3;
    localparam int STS_INT_BIT  = 2;
    localparam int STS_SMI_BIT  = 3;
    localparam int STS_NMI_BIT  = 11;
    localparam int STS_SERR_BIT = 12;

    // ********************************************************************
    // timing: one countdown step per tick
    // ********************************************************************
    localparam int unsigned TICK_MS      = 600;
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned TICK_CYCLES_DEFAULT = TICK_MS * CLK_MHZ * 1000;

endpackage : wdt_pkg
